// File: pbm_pkg.sv
package pbm_pkg;
   // ==========================================
   // pin positions
   localparam int PIN_COUNT      = 8;
   localparam int PIN_SS         = 0;
   localparam int PIN_SCK        = 1;
   localparam int PIN_MOSI       = 2;
   localparam int PIN_MISO       = 3;
   localparam int PIN_TMR0_CMPA   = 4;
   localparam int PIN_TMR1_CMPA   = 5;
   localparam int PIN_TMR1_CMPB   = 6;
   localparam int PIN_TMR2_CMPA   = 7;
   localparam int PIN_CHANGE_BASE = 8;
   localparam int PD_EXT_IRQ_PIN  = 1;
   localparam int PD_CAPTURE_PIN  = 0;
   localparam int PD_COUNT       = 8;
   // ==========================================
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// File: pbm_ovr_if.sv
`timescale 1ns/1ps
interface pbm_ovr_if;
   // ==========================================
   // per-pin override bundle
   logic [7:0] pullup_override_enable;
   logic [7:0] pullup_override_value;
   logic [7:0] direction_override_enable;
   logic [7:0] direction_override_value;
   logic [7:0] value_override_enable;
   logic [7:0] value_override_value;
   logic [7:0] input_enable_override_enable;
   logic [7:0] input_enable_override_value;
   modport src (
      output pullup_override_enable,
      output pullup_override_value,
      output direction_override_enable,
      output direction_override_value,
      output value_override_enable,
      output value_override_value,
      output input_enable_override_enable,
      output input_enable_override_value
   );
   modport dst (
      input  pullup_override_enable,
      input  pullup_override_value,
      input  direction_override_enable,
      input  direction_override_value,
      input  value_override_enable,
      input  value_override_value,
      input  input_enable_override_enable,
      input  input_enable_override_value
   );
endinterface

// File: pbm_pad_ctl.sv
`timescale 1ns/1ps
module pbm_pad_ctl #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   pbm_ovr_if.dst                ovr,
   input  wire logic [WIDTH-1:0] dir_bits,
   input  wire logic [WIDTH-1:0] port_bits,
   input  wire logic             global_pullup_disable,
   input  wire logic             sleep_clamp,
   input  wire logic [WIDTH-1:0] pad_in,
   output logic      [WIDTH-1:0] pad_out,
   output logic      [WIDTH-1:0] pad_oe_n,
   output logic      [WIDTH-1:0] pullup_on,
   output logic      [WIDTH-1:0] pad_raw_in,
   output logic      [WIDTH-1:0] pin_value
);
   typedef struct packed {
      logic [WIDTH-1:0] out;
      logic [WIDTH-1:0] oe_n;
      logic [WIDTH-1:0] pu;
      logic [WIDTH-1:0] raw;
      logic [WIDTH-1:0] sync1;
      logic [WIDTH-1:0] sync2;
   } pbm_pad_state_t;
   pbm_pad_state_t st_reg;
   pbm_pad_state_t st_next;
   logic [WIDTH-1:0] drv;
   logic [WIDTH-1:0] die;
   // ==========================================
   // per-pin override combine
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : pin
         assign drv[g] = ovr.direction_override_enable[g] ? ovr.direction_override_value[g]
                                                          : dir_bits[g];
         assign die[g] = ovr.input_enable_override_enable[g] ? ovr.input_enable_override_value[g]
                                                             : ~sleep_clamp;
      end
   endgenerate
   always_comb begin
      st_next       = st_reg;
      st_next.oe_n  = ~drv;
      st_next.out   = (ovr.value_override_enable & ovr.value_override_value)
                    | (~ovr.value_override_enable & port_bits);
      st_next.pu    = (ovr.pullup_override_enable & ovr.pullup_override_value)
                    | (~ovr.pullup_override_enable & ~dir_bits & port_bits
                       & {WIDTH{~global_pullup_disable}});
      st_next.raw   = pad_in & die;
      st_next.sync1 = st_reg.raw;
      st_next.sync2 = st_reg.sync1;
      if (sys_rst) begin
         st_next      = '0;
         st_next.oe_n = '1;
      end
   end
   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end
   assign pad_out    = st_reg.out;
   assign pad_oe_n   = st_reg.oe_n;
   assign pullup_on  = st_reg.pu;
   assign pad_raw_in = st_reg.raw;
   assign pin_value  = st_reg.sync2;
endmodule

// File: pbm_port_b_mux.sv
`timescale 1ns/1ps
module pbm_port_b_mux (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  direction_bits,
   input  wire logic [7:0]  output_bits,
   input  wire logic        global_pullup_disable,
   input  wire logic        sleep_clamp,
   input  wire logic [7:0]  pad_in,
   output logic      [7:0]  pad_out,
   output logic      [7:0]  pad_oe_n,
   output logic      [7:0]  pullup_on,
   output logic      [7:0]  pin_value,
   input  wire logic        timer2_compare_a_out,
   input  wire logic        timer2_compare_a_en,
   input  wire logic        timer1_compare_b_out,
   input  wire logic        timer1_compare_b_en,
   input  wire logic        timer1_compare_a_out,
   input  wire logic        timer1_compare_a_en,
   input  wire logic        timer0_compare_a_out,
   input  wire logic        timer0_compare_a_en,
   input  wire logic        spi_enable_bit,
   input  wire logic        spi_master_select_bit,
   input  wire logic        spi_master_data_out,
   input  wire logic        spi_slave_data_out,
   input  wire logic        spi_clock_out,
   output logic             spi_master_data_in,
   output logic             spi_slave_data_in,
   output logic             spi_clock_in,
   output logic             spi_slave_select_in,
   output logic             spi_slave_active,
   input  wire logic [7:0]  pin_change_mask,
   input  wire logic        pin_change_group_enable,
   output logic      [15:8] pin_change_source,
   input  wire logic [7:0]  port_d_pad_in,
   output logic             external_interrupt_zero,
   output logic             timer1_capture_input
);
   pbm_ovr_if ovr ();
   logic [7:0] raw_in;
   logic       spi_mst;
   logic       spi_slv;
   logic [3:0] cmp_en;
   logic [3:0] cmp_val;
   typedef struct packed {
      logic [7:0] pd_sync1;
      logic [7:0] pd_sync2;
      logic       mi;
      logic       si;
      logic       ck;
      logic       ss;
      logic       act;
   } pbm_top_state_t;
   pbm_top_state_t st_reg;
   pbm_top_state_t st_next;

   // ==========================================
   // spi role decode
   assign spi_mst = spi_enable_bit & spi_master_select_bit;
   assign spi_slv = spi_enable_bit & ~spi_master_select_bit;

   // ==========================================
   // timer compare outputs, pin 4 upwards
   assign cmp_en  = {timer2_compare_a_en,
                     timer1_compare_b_en,
                     timer1_compare_a_en,
                     timer0_compare_a_en};
   assign cmp_val = {timer2_compare_a_out,
                     timer1_compare_b_out,
                     timer1_compare_a_out,
                     timer0_compare_a_out};

   // ==========================================
   // override generation
   always_comb begin
      // defaults: the port registers own every pin
      ovr.pullup_override_enable       = 8'h00;
      ovr.pullup_override_value        = 8'h00;
      ovr.direction_override_enable    = 8'h00;
      ovr.direction_override_value     = 8'h00;
      ovr.value_override_enable        = 8'h00;
      ovr.value_override_value         = 8'h00;
      ovr.input_enable_override_enable = 8'h00;
      ovr.input_enable_override_value  = 8'h00;
      // pins 7..4: compare output replaces the port bit, ddr keeps direction
      ovr.value_override_enable[pbm_pkg::PIN_TMR2_CMPA] = cmp_en[3];
      ovr.value_override_value[pbm_pkg::PIN_TMR2_CMPA]  = cmp_val[3];
      ovr.value_override_enable[pbm_pkg::PIN_TMR1_CMPB] = cmp_en[2];
      ovr.value_override_value[pbm_pkg::PIN_TMR1_CMPB]  = cmp_val[2];
      ovr.value_override_enable[pbm_pkg::PIN_TMR1_CMPA] = cmp_en[1];
      ovr.value_override_value[pbm_pkg::PIN_TMR1_CMPA]  = cmp_val[1];
      ovr.value_override_enable[pbm_pkg::PIN_TMR0_CMPA] = cmp_en[0];
      ovr.value_override_value[pbm_pkg::PIN_TMR0_CMPA]  = cmp_val[0];
      // pin 3: input as master, slave output as slave
      ovr.direction_override_enable[pbm_pkg::PIN_MISO] = spi_mst;
      ovr.direction_override_value[pbm_pkg::PIN_MISO]  = 1'b0;
      ovr.value_override_enable[pbm_pkg::PIN_MISO]     = spi_slv;
      ovr.value_override_value[pbm_pkg::PIN_MISO]      = spi_slave_data_out;
      // pin 2: master output, input as slave
      ovr.direction_override_enable[pbm_pkg::PIN_MOSI] = spi_slv;
      ovr.direction_override_value[pbm_pkg::PIN_MOSI]  = 1'b0;
      ovr.value_override_enable[pbm_pkg::PIN_MOSI]     = spi_mst;
      ovr.value_override_value[pbm_pkg::PIN_MOSI]      = spi_master_data_out;
      // pin 1: clock output as master, input as slave
      ovr.direction_override_enable[pbm_pkg::PIN_SCK]  = spi_slv;
      ovr.direction_override_value[pbm_pkg::PIN_SCK]   = 1'b0;
      ovr.value_override_enable[pbm_pkg::PIN_SCK]      = spi_mst;
      ovr.value_override_value[pbm_pkg::PIN_SCK]       = spi_clock_out;
      // pin 0: input as slave, value never overridden
      ovr.direction_override_enable[pbm_pkg::PIN_SS]   = spi_slv;
      ovr.direction_override_value[pbm_pkg::PIN_SS]    = 1'b0;
      ovr.value_override_enable[pbm_pkg::PIN_SS]       = 1'b0;
      ovr.value_override_value[pbm_pkg::PIN_SS]        = 1'b0;
      // forced spi inputs keep the port bit as pull-up control
      ovr.pullup_override_enable[3:0] = ovr.direction_override_enable[3:0];
      ovr.pullup_override_value[3:0]  = output_bits[3:0] & {4{~global_pullup_disable}};
      // masked pin-change pins stay sensed in sleep while pin_change_group_enable is set
      ovr.input_enable_override_enable = pin_change_mask & {8{pin_change_group_enable}};
      ovr.input_enable_override_value  = 8'hff;
   end

   pbm_pad_ctl #(.WIDTH(pbm_pkg::PIN_COUNT)) u_pad (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .ovr                   (ovr),
      .dir_bits              (direction_bits),
      .port_bits             (output_bits),
      .global_pullup_disable (global_pullup_disable),
      .sleep_clamp           (sleep_clamp),
      .pad_in                (pad_in),
      .pad_out               (pad_out),
      .pad_oe_n              (pad_oe_n),
      .pullup_on             (pullup_on),
      .pad_raw_in            (raw_in),
      .pin_value             (pin_value)
   );
   // ==========================================
   // spi input routing and port d synchroniser
   always_comb begin
      st_next          = st_reg;
      st_next.pd_sync1 = port_d_pad_in;
      st_next.pd_sync2 = st_reg.pd_sync1;
      st_next.mi       = raw_in[pbm_pkg::PIN_MISO];
      st_next.si       = raw_in[pbm_pkg::PIN_MOSI];
      st_next.ck       = raw_in[pbm_pkg::PIN_SCK];
      st_next.ss       = raw_in[pbm_pkg::PIN_SS];
      st_next.act      = spi_slv & ~st_reg.ss;
      if (sys_rst) begin
         st_next    = '0;
         st_next.ss = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end
   assign spi_master_data_in  = st_reg.mi;
   assign spi_slave_data_in   = st_reg.si;
   assign spi_clock_in        = st_reg.ck;
   assign spi_slave_select_in = st_reg.ss;
   assign spi_slave_active    = st_reg.act;
   assign external_interrupt_zero = st_reg.pd_sync2[pbm_pkg::PD_EXT_IRQ_PIN];
   assign timer1_capture_input    = st_reg.pd_sync2[pbm_pkg::PD_CAPTURE_PIN];

   // ==========================================
   // pin-change sources, pin n to source 8+n
   genvar n;
   generate
      for (n = 0; n < pbm_pkg::PIN_COUNT; n++) begin : pcs_map
         assign pin_change_source[pbm_pkg::PIN_CHANGE_BASE + n] = raw_in[n];
      end
   endgenerate
endmodule

// File: pbm_far_model.sv
`timescale 1ns/1ps
module pbm_far_model (
   input  wire logic [10:0] cfg,
   output logic      [3:0]  cmp_out,
   output logic      [3:0]  cmp_en,
   output logic      [2:0]  spi_out
);
   // ==========================================
   // timers and spi hold the levels the bench selects
   assign {cmp_out, cmp_en, spi_out} = cfg;
endmodule

// File: pbm_port_b_mux_assertions.sv
`timescale 1ns/1ps
module pbm_port_b_mux_assertions (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  direction_bits,
   input  wire logic [7:0]  output_bits,
   input  wire logic        global_pullup_disable,
   input  wire logic [7:0]  pad_out,
   input  wire logic [7:0]  pad_oe_n,
   input  wire logic [7:0]  pullup_on,
   input  wire logic        timer2_compare_a_out,
   input  wire logic        timer2_compare_a_en,
   input  wire logic        spi_enable_bit,
   input  wire logic        spi_master_select_bit,
   input  wire logic        spi_master_data_out,
   input  wire logic        spi_slave_data_out,
   input  wire logic [7:0]  port_d_pad_in,
   input  wire logic        external_interrupt_zero,
   input  wire logic [15:8] pin_change_source
);
   // ==========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic ok;
   logic ok2;
   logic mst;
   assign mst = spi_enable_bit & spi_master_select_bit;
   always_ff @(posedge clk) begin
      ok <= !sys_rst;
      ok2 <= ok && !sys_rst;
   end
   a_cmp_dir: assert property (ok |-> pad_oe_n[7:4] == ~$past(direction_bits[7:4]))
      else $error("compare pin direction wrong");
   a_cmp_value: assert property (ok && $past(timer2_compare_a_en) && !pad_oe_n[7]
      |-> pad_out[7] == $past(timer2_compare_a_out)) else $error("compare value wrong");
   a_miso_master: assert property (ok && $past(mst) |-> pad_oe_n[3])
      else $error("miso not input as master");
   a_slave_inputs: assert property (ok && $past(spi_enable_bit && !spi_master_select_bit)
      |-> pad_oe_n[2:0] == 3'h7) else $error("slave pins not inputs");
   a_pullup_rule: assert property (ok |-> pullup_on == (pad_oe_n & $past(output_bits)
      & ~{8{$past(global_pullup_disable)}})) else $error("pull-up wrong");
   a_miso_out: assert property (ok && $past(spi_enable_bit && !mst) && !pad_oe_n[3]
      |-> pad_out[3] == $past(spi_slave_data_out)) else $error("miso value wrong");
   a_mosi_out: assert property (ok && $past(mst) && !pad_oe_n[2]
      |-> pad_out[2] == $past(spi_master_data_out)) else $error("mosi value wrong");
   a_ss_value: assert property (ok && !pad_oe_n[0] |-> pad_out[0] == $past(output_bits[0]))
      else $error("ss value overridden");
   a_external_interrupt_zero_route: assert property (ok2 |-> external_interrupt_zero == $past(port_d_pad_in[1], 2))
      else $error("external_interrupt_zero routing wrong");
   c_slave: cover property (ok && pad_oe_n[3:0] == 4'h7);
   c_master: cover property (ok && pad_oe_n[3:0] == 4'h8);
   c_change: cover property (|pin_change_source);
endmodule
bind pbm_port_b_mux pbm_port_b_mux_assertions u_pbm_port_b_mux_assertions (
   .clk                   (clk),
   .sys_rst               (sys_rst),
   .direction_bits        (direction_bits),
   .output_bits           (output_bits),
   .global_pullup_disable (global_pullup_disable),
   .pad_out               (pad_out),
   .pad_oe_n              (pad_oe_n),
   .pullup_on             (pullup_on),
   .timer2_compare_a_out  (timer2_compare_a_out),
   .timer2_compare_a_en   (timer2_compare_a_en),
   .spi_enable_bit        (spi_enable_bit),
   .spi_master_select_bit (spi_master_select_bit),
   .spi_master_data_out   (spi_master_data_out),
   .spi_slave_data_out    (spi_slave_data_out),
   .port_d_pad_in         (port_d_pad_in),
   .external_interrupt_zero (external_interrupt_zero),
   .pin_change_source     (pin_change_source)
);

// File: pbm_port_b_mux_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module pbm_port_b_mux_test;
   logic clk = 0, sys_rst = 1, pu_dis = 0, slp = 0, spi_en = 0, mst = 0, grp = 0;
   logic [7:0] dir = 0, outb = 0, pin = 0, msk = 0, pd = 0, po, poe, pu, pv;
   logic [10:0] cfg = 0;
   logic [3:0] co, ce;
   logic [2:0] so;
   logic [15:8] pcs;
   logic sact, sdi, ei, cap, ssi, smi, sck;
   int n_fail = 0, tests_run = 0;
   pbm_far_model u_pbm_far_model (.cfg(cfg), .cmp_out(co), .cmp_en(ce), .spi_out(so));
   pbm_port_b_mux u_pbm_port_b_mux (.clk(clk), .sys_rst(sys_rst), .direction_bits(dir),
      .output_bits(outb), .global_pullup_disable(pu_dis), .sleep_clamp(slp), .pad_in(pin),
      .pad_out(po), .pad_oe_n(poe), .pullup_on(pu), .pin_value(pv),
      .timer2_compare_a_out(co[3]), .timer2_compare_a_en(ce[3]),
      .timer1_compare_b_out(co[2]), .timer1_compare_b_en(ce[2]),
      .timer1_compare_a_out(co[1]), .timer1_compare_a_en(ce[1]),
      .timer0_compare_a_out(co[0]), .timer0_compare_a_en(ce[0]),
      .spi_enable_bit(spi_en), .spi_master_select_bit(mst), .spi_master_data_out(so[2]),
      .spi_slave_data_out(so[1]), .spi_clock_out(so[0]), .spi_master_data_in(smi),
      .spi_slave_data_in(sdi), .spi_clock_in(sck), .spi_slave_select_in(ssi),
      .spi_slave_active(sact), .pin_change_mask(msk), .pin_change_group_enable(grp),
      .pin_change_source(pcs), .port_d_pad_in(pd), .external_interrupt_zero(ei),
      .timer1_capture_input(cap));
   // ==========================================
   // clock and tasks
   initial forever #10 clk = ~clk;
   task automatic step(input logic [7:0] d, o, p);
      @(negedge clk);
      dir = d;
      outb = o;
      pin = p;
      repeat (5) @(negedge clk);
   endtask
   task automatic results;
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================
   // scenarios
   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 0;
      `CHK({poe, po, pu, ssi}, {8'hff, 8'h00, 8'h00, 1'b1})
      cfg = 11'h57d;
      step(8'hf0, 8'h0f, 8'h00);
      `CHK({poe[7:4], po[7:4]}, 8'h0a)
      cfg = 11'h505;
      step(8'hf0, 8'h50, 8'h00);
      `CHK(po[7:4], 4'h5)
      step(8'h00, 8'h50, 8'h00);
      `CHK({poe[7:4], pu[7:4]}, 8'hf5)
      spi_en = 1;
      mst = 1;
      cfg = 11'h57d;
      step(8'h0f, 8'h08, 8'h00);
      `CHK({poe[3:0], po[2:1], pu[3]}, 7'h47)
      mst = 0;
      cfg = 11'h57f;
      step(8'h0f, 8'h07, 8'h00);
      `CHK({poe[3:0], po[3], pu[3:0]}, 9'h0f7)
      `CHK({sact, ssi}, 2'b10)
      pu_dis = 1;
      step(8'h0f, 8'h07, 8'h05);
      `CHK({pu, sact, sdi}, 10'h001)
      spi_en = 0;
      pu_dis = 0;
      slp = 1;
      msk = 8'h05;
      grp = 1;
      step(8'h00, 8'h00, 8'hff);
      `CHK(pcs, 8'h05)
      grp = 0;
      step(8'h00, 8'h00, 8'hff);
      `CHK(pcs, 8'h00)
      slp = 0;
      pd = 8'h02;
      step(8'h00, 8'h00, 8'h5a);
      `CHK({pcs, ei, cap}, 10'h16a)
      pd = 8'h01;
      step(8'h00, 8'h00, 8'h5a);
      `CHK({ei, cap}, 2'b01)
      `CHK({pv, smi, sck}, 10'h16b)
      results();
   end
endmodule
